// >>> hw/vout_setpoint_defs.svh
`ifndef VOUT_SETPOINT_DEFS_SVH
`define VOUT_SETPOINT_DEFS_SVH
// clock rate in kHz (25 MHz)
`define CLK_KHZ            25000
// strap defaults
`define JE_CODE_LOW        8'h50
`define JE_CODE_HIGH       8'h5F
`define JE_ADDR_SHORT_GND  7'h45
`define JE_ADDR_RES_GND    7'h44
`define JE_ADDR_RES_VIN    7'h47
`define JE_ADDR_SHORT_VIN  7'h46
// four-strap steps in 5 mV codes: base 400 mV, 50 mV step, +25 mV, +500 mV
`define STRAP_STEP_CODES   8'h0A
`define STRAP_FINE_CODES   8'h05
`define STRAP_COARSE_CODES 8'h64
// reset defaults
`define SLEW_DEFAULT       2'h2
`define RANGE_DEFAULT      2'h2
// slew rates in uV/us, one per selector value
`define SLEW_UV_US_0       10000
`define SLEW_UV_US_1       5000
`define SLEW_UV_US_2       1250
`define SLEW_UV_US_3       500
// range step sizes in uV
`define STEP_UV_0          1250
`define STEP_UV_1          2500
`define STEP_UV_2          5000
// spread spectrum: +-10 percent sweep
`define SPREAD_PCT         10
`endif

// >>> hw/vout_setpoint_pkg.sv
package vout_setpoint_pkg;
   typedef enum logic [1:0] {ST_OFF, ST_SOFTSTART, ST_RUN, ST_RAMP} phase_e;
   typedef logic [7:0] code_t;
endpackage

// >>> hw/ramp_if.sv
`timescale 1ns/1ns
// ramp generator link between control and stepper
interface ramp_if;
   logic [7:0]  target;
   logic [15:0] interval;
   logic        load;
   logic [7:0]  current;
   logic        busy;
   modport ctrl (output target, output interval, output load, input current, input busy);
   modport gen  (input target, input interval, input load, output current, output busy);
endinterface

// >>> hw/setpoint_ramp.sv
`timescale 1ns/1ns
`include "vout_setpoint_defs.svh"
// steps the internal setpoint one code per interval toward its target
module setpoint_ramp (
   input  wire logic clk_sys,
   input  wire logic rst,
   ramp_if.gen       rp
);
   logic [15:0] tick;
   logic [7:0]  goal;

   // -------------------------------------------------------------
   // stepper
   // -------------------------------------------------------------
   // latch goal, step one code each interval
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         goal       <= 8'h00;
         rp.current <= 8'h00;
         tick       <= 16'h0000;
      end else if (rp.load) begin
         goal <= rp.target;
         tick <= 16'h0000;
      end else if (goal != rp.current) begin
         if (tick >= rp.interval) begin
            tick <= 16'h0000;
            if (goal > rp.current) begin
               rp.current <= rp.current + 8'h01;
            end else begin
               rp.current <= rp.current - 8'h01;
            end
         end else begin
            tick <= tick + 16'h0001;
         end
      end else begin
         tick <= 16'h0000;
      end
   end

   assign rp.busy = rp.load || (goal != rp.current);
endmodule

// >>> hw/vout_setpoint_dvs_mode_ctrl.sv
`timescale 1ns/1ns
`include "vout_setpoint_defs.svh"
module vout_setpoint_dvs_mode_ctrl #(
   parameter int SYNC_MAX_GAP = 64,    // cycles without sync edge before clock deemed lost
   parameter int SYNC_MIN_EDGES = 4,   // edges counted before the next rising edge calls sync clock valid
   parameter int SPREAD_STEPS = 64,    // triangle half-period in steps
   parameter int SOFTSTART_CYCLES = 25000
) (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       enable,
   input  wire logic       single_strap_variant,
   input  wire logic [1:0] single_strap_select,
   input  wire logic [1:0] strap_pin_a,
   input  wire logic [1:0] strap_pin_b,
   input  wire logic       strap_fine_offset,
   input  wire logic       strap_coarse_offset,
   input  wire logic [7:0] setpoint_code,
   input  wire logic       setpoint_write,
   input  wire logic [1:0] range_select,
   input  wire logic [1:0] softstart_time_sel,
   input  wire logic [1:0] slew_rate_sel,
   input  wire logic       droop_enable,
   input  wire logic [7:0] droop_offset,
   input  wire logic [7:0] load_level,
   input  wire logic       forced_pwm_bit,
   input  wire logic       spread_enable,
   input  wire logic       secondary_mode,
   input  wire logic       mode_sync,
   output logic [7:0]      output_target_code,
   output logic [1:0]      active_range,
   output logic [1:0]      active_softstart_time,
   output logic [6:0]      i2c_address,
   output logic            voltage_transition,
   output logic            softstart_active,
   output logic            forced_pwm,
   output logic            sync_locked,
   output logic            switch_clock_ext,
   output logic            spread_spectrum,
   output logic signed [7:0] spread_offset_pct,
   output logic [7:0]      droop_target_code
);
   ramp_if rp ();
   vout_setpoint_pkg::phase_e phase;
   logic [7:0]  defaultCode;
   logic [6:0]  next_addr;
   logic [7:0]  pendingCode;
   logic [1:0]  pendingRange;
   logic [1:0]  pendingSs;
   logic        pendingSet;
   logic        strapTaken;
   logic        enablePrev;
   logic [1:0]  slewActive;
   logic [31:0] ssCount;
   logic [31:0] next_interval;

   // -------------------------------------------------------------
   // strap decode
   // -------------------------------------------------------------
   // straps: 0 short gnd, 1 res gnd, 2 res vin, 3 short vin
   // straps must settle before reset release
   always_comb begin
      unique case (single_strap_select)
         2'h0: next_addr = `JE_ADDR_SHORT_GND;
         2'h1: next_addr = `JE_ADDR_RES_GND;
         2'h2: next_addr = `JE_ADDR_RES_VIN;
         2'h3: next_addr = `JE_ADDR_SHORT_VIN;
      endcase
      if (single_strap_variant) begin
         defaultCode = (single_strap_select == 2'h3) ? `JE_CODE_HIGH : `JE_CODE_LOW;
      end else begin
         defaultCode = 8'({strap_pin_a, strap_pin_b}) * `STRAP_STEP_CODES
                     + (strap_fine_offset ? `STRAP_FINE_CODES : 8'h00)
                     + (strap_coarse_offset ? `STRAP_COARSE_CODES : 8'h00);
      end
   end

   // capture address once after reset release
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         i2c_address <= 7'h00;
         strapTaken  <= 1'b0;
      end else if (!strapTaken) begin
         i2c_address <= next_addr;
         strapTaken  <= 1'b1;
      end
   end

   // -------------------------------------------------------------
   // pending settings
   // -------------------------------------------------------------
   // host writes stored; range/ss only go live via setpoint write
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pendingCode  <= 8'h00;
         pendingRange <= `RANGE_DEFAULT;
         pendingSs    <= 2'h0;
         pendingSet   <= 1'b0;
      end else if (setpoint_write) begin
         pendingCode  <= setpoint_code;
         pendingRange <= range_select;
         pendingSs    <= softstart_time_sel;
         pendingSet   <= 1'b1;
      end
   end

   // -------------------------------------------------------------
   // sequencing
   // -------------------------------------------------------------
   // off -> soft-start -> run; applies pending values only when idle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         phase                 <= vout_setpoint_pkg::ST_OFF;
         enablePrev            <= 1'b0;
         rp.target             <= 8'h00;
         rp.load               <= 1'b0;
         active_range          <= `RANGE_DEFAULT;
         active_softstart_time <= 2'h0;
         slewActive            <= `SLEW_DEFAULT;
         ssCount               <= 32'h0;
         softstart_active      <= 1'b0;
         voltage_transition    <= 1'b0;
      end else begin
         enablePrev <= enable;
         rp.load    <= 1'b0;
         unique case (phase)
            vout_setpoint_pkg::ST_OFF: begin
               softstart_active   <= 1'b0;
               voltage_transition <= 1'b0;
               if (enable && !enablePrev) begin
                  slewActive <= slew_rate_sel;
                  active_softstart_time <= pendingSs;
                  if (pendingSet) begin
                     rp.target    <= pendingCode;
                     active_range <= pendingRange;
                  end else begin
                     rp.target <= defaultCode;
                  end
                  rp.load          <= 1'b1;
                  ssCount          <= 32'h0;
                  softstart_active <= 1'b1;
                  phase            <= vout_setpoint_pkg::ST_SOFTSTART;
               end
            end

            vout_setpoint_pkg::ST_SOFTSTART: begin
               // target frozen here; new writes wait
               if (!enable) begin
                  phase <= vout_setpoint_pkg::ST_OFF;
               end else if (!rp.busy && ssCount >= 32'(SOFTSTART_CYCLES)) begin
                  softstart_active <= 1'b0;
                  phase            <= vout_setpoint_pkg::ST_RUN;
               end else begin
                  ssCount <= ssCount + 32'h1;
               end
            end

            vout_setpoint_pkg::ST_RUN: begin
               if (!enable) begin
                  phase <= vout_setpoint_pkg::ST_OFF;
               end else if (pendingSet && (pendingCode != rp.target
                            || pendingRange != active_range)) begin
                  rp.target          <= pendingCode;
                  active_range       <= pendingRange;
                  active_softstart_time <= pendingSs;
                  slewActive         <= slew_rate_sel;
                  rp.load            <= 1'b1;
                  voltage_transition <= 1'b1;
                  phase              <= vout_setpoint_pkg::ST_RAMP;
               end
            end

            vout_setpoint_pkg::ST_RAMP: begin
               // further writes held until ramp done
               if (!enable) begin
                  phase <= vout_setpoint_pkg::ST_OFF;
               end else if (!rp.busy) begin
                  voltage_transition <= 1'b0;
                  phase              <= vout_setpoint_pkg::ST_RUN;
               end
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // ramp interval
   // -------------------------------------------------------------
   // cycles per code = step_uV * kHz / (slew_uV_us * 1000)
   // truncated interval: slew slightly fast
   function automatic logic [31:0] step_uv(input logic [1:0] r);
      unique case (r)
         2'h0: step_uv = `STEP_UV_0;
         2'h1: step_uv = `STEP_UV_1;
         default: step_uv = `STEP_UV_2;
      endcase
   endfunction

   function automatic logic [31:0] slew_uv(input logic [1:0] s);
      unique case (s)
         2'h0: slew_uv = `SLEW_UV_US_0;
         2'h1: slew_uv = `SLEW_UV_US_1;
         2'h2: slew_uv = `SLEW_UV_US_2;
         2'h3: slew_uv = `SLEW_UV_US_3;
      endcase
   endfunction

   always_comb begin
      next_interval = (step_uv(active_range) * (`CLK_KHZ / 1000))
                    / slew_uv(slewActive);
   end

   assign rp.interval = (next_interval == 32'h0) ? 16'h0000 : 16'(next_interval - 32'h1);

   setpoint_ramp ramper (
      .clk_sys (clk_sys),
      .rst     (rst),
      .rp      (rp)
   );

   // code out of stepper; voltage = 0.4 V + code * step of active_range
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         output_target_code <= 8'h00;
      end else begin
         output_target_code <= rp.current;
      end
   end

   // -------------------------------------------------------------
   // droop
   // -------------------------------------------------------------
   // offset swings from +droop at no load to -droop at full load
   logic [8:0] droopSpan;
   logic [8:0] droopCode;
   logic       droopLow;

   // a span beyond code plus offset would wrap, so it floors at zero
   always_comb begin
      droopSpan = 9'((17'({1'b0, droop_offset}) * 17'({load_level, 1'b0})) >> 8);
      droopCode = 9'({1'b0, rp.current}) + 9'({1'b0, droop_offset}) - droopSpan;
      droopLow  = ({1'b0, rp.current} + {1'b0, droop_offset}) < droopSpan;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         droop_target_code <= 8'h00;
      end else if (droop_enable) begin
         droop_target_code <= droopLow ? 8'h00
                            : droopCode[8] ? 8'hFF : droopCode[7:0];
      end else begin
         droop_target_code <= rp.current;
      end
   end

   // -------------------------------------------------------------
   // mode / sync
   // -------------------------------------------------------------
   logic        syncPrev;
   logic [15:0] syncGap;
   logic [3:0]  syncEdges;
   // detect a toggling clock on the mode pin
   // a static level never locks
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         syncPrev    <= 1'b0;
         syncGap     <= 16'h0000;
         syncEdges   <= 4'h0;
         sync_locked <= 1'b0;
      end else begin
         syncPrev <= mode_sync;
         if (mode_sync && !syncPrev) begin
            syncGap <= 16'h0000;
            if (syncEdges != 4'(SYNC_MIN_EDGES)) begin
               syncEdges <= syncEdges + 4'h1;
            end else begin
               sync_locked <= 1'b1;
            end
         end else if (syncGap >= 16'(SYNC_MAX_GAP)) begin
            syncEdges   <= 4'h0;
            sync_locked <= 1'b0;
         end else begin
            syncGap <= syncGap + 16'h0001;
         end
      end
   end

   assign forced_pwm = mode_sync || forced_pwm_bit || sync_locked;
   assign switch_clock_ext = sync_locked || secondary_mode;

   // -------------------------------------------------------------
   // spread spectrum
   // -------------------------------------------------------------
   assign spread_spectrum = spread_enable && forced_pwm && !switch_clock_ext;

   logic [15:0] triPos;
   logic        triDown;
   // triangle sweep of -10..+10 percent
   // sweep restarts low on every enable
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         triPos            <= 16'h0000;
         triDown           <= 1'b0;
         spread_offset_pct <= 8'sh00;
      end else if (!spread_spectrum) begin
         triPos            <= 16'h0000;
         triDown           <= 1'b0;
         spread_offset_pct <= 8'sh00;
      end else begin
         if (!triDown) begin
            triPos  <= triPos + 16'h0001;
            triDown <= (triPos == 16'(SPREAD_STEPS - 1));
         end else begin
            triPos  <= triPos - 16'h0001;
            triDown <= (triPos != 16'h0001);
         end
         spread_offset_pct <= 8'((32'(triPos) * 32'(2 * `SPREAD_PCT)) / 32'(SPREAD_STEPS))
                            - 8'(`SPREAD_PCT);
      end
   end
endmodule

// >>> bench/vout_setpoint_monitor.sv
`timescale 1ns/1ns
// ------------------------------
// port checker
// ------------------------------
module vout_setpoint_monitor #(
   parameter int SYNC_MAX_GAP = 64
) (
   input wire logic              clk_sys,
   input wire logic              rst,
   input wire logic              enable,
   input wire logic              forced_pwm_bit,
   input wire logic              spread_enable,
   input wire logic              secondary_mode,
   input wire logic              mode_sync,
   input wire logic [7:0]        output_target_code,
   input wire logic [1:0]        active_range,
   input wire logic [1:0]        active_softstart_time,
   input wire logic [6:0]        i2c_address,
   input wire logic              voltage_transition,
   input wire logic              softstart_active,
   input wire logic              forced_pwm,
   input wire logic              sync_locked,
   input wire logic              switch_clock_ext,
   input wire logic              spread_spectrum,
   input wire logic signed [7:0] spread_offset_pct
);
   logic prevSync;
   int   quietCycles;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // cycles since the sync pin last moved
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prevSync <= 1'b0;
         quietCycles <= 0;
      end else begin
         prevSync <= mode_sync;
         if (mode_sync != prevSync) quietCycles <= 0;
         else if (quietCycles < 1000) quietCycles <= quietCycles + 1;
      end
   end
   // multi-cycle phases
   sequence ssHeld;
      softstart_active ##1 softstart_active ##1 softstart_active;
   endsequence
   sequence rampHeld;
      voltage_transition ##1 voltage_transition ##1 voltage_transition;
   endsequence
   sequence codeMoved;
      enable && $past(enable) && !$stable(output_target_code);
   endsequence
   AST_SS_HOLD: assert property (ssHeld |-> $stable(active_range) && $stable(active_softstart_time))
      else $error("setting changed during soft-start");
   AST_RAMP_HOLD: assert property (rampHeld |-> $stable(active_range))
      else $error("range changed during ramp");
   AST_STEP_ONE: assert property (codeMoved |->
      output_target_code == $past(output_target_code) + 8'h01
      || output_target_code == $past(output_target_code) - 8'h01)
      else $error("code moved by more than one");
   AST_FPWM_OR: assert property (forced_pwm == (mode_sync | forced_pwm_bit | sync_locked))
      else $error("forced pwm not the or of its sources");
   AST_SYNC_LOST: assert property (quietCycles > SYNC_MAX_GAP + 16 |-> !sync_locked)
      else $error("lock held without sync edges");
   AST_SWCLK_EXT: assert property (switch_clock_ext == (sync_locked | secondary_mode))
      else $error("external clock select wrong");
   AST_SPREAD_GATE: assert property (spread_spectrum |-> spread_enable && forced_pwm && !sync_locked)
      else $error("spread active without its conditions");
   AST_SPREAD_RANGE: assert property (spread_offset_pct <= 8'sd10 && spread_offset_pct >= -8'sd10)
      else $error("spread offset out of range");
   AST_ADDR_STABLE: assert property (!$past(rst) && !$past(rst, 2) |-> $stable(i2c_address))
      else $error("address moved after capture");
endmodule

bind vout_setpoint_dvs_mode_ctrl vout_setpoint_monitor #(.SYNC_MAX_GAP(SYNC_MAX_GAP))
   vout_setpoint_monitor_i (.clk_sys, .rst, .enable, .forced_pwm_bit, .spread_enable,
   .secondary_mode, .mode_sync, .output_target_code, .active_range, .active_softstart_time,
   .i2c_address, .voltage_transition, .softstart_active, .forced_pwm, .sync_locked,
   .switch_clock_ext, .spread_spectrum, .spread_offset_pct);

// >>> bench/host_model.sv
`timescale 1ns/1ns
// ------------------------------
// serial host and sync clock source
// ------------------------------
module host_model (
   input  wire logic  clk_sys,
   output logic [7:0] setpoint_code,
   output logic       setpoint_write,
   output logic [1:0] range_select,
   output logic [1:0] softstart_time_sel,
   output logic       mode_sync
);
   // idle values
   initial begin
      setpoint_code = 8'h00;
      setpoint_write = 1'b0;
      range_select = 2'h2;
      softstart_time_sel = 2'h0;
      mode_sync = 1'b0;
   end
   // range only takes effect together with a setpoint write
   task automatic write_setpoint(input logic [7:0] code, input logic [1:0] rng, input logic wr);
      @(negedge clk_sys);
      setpoint_code = code;
      range_select = rng;
      softstart_time_sel = code[5:4];
      setpoint_write = wr;
      @(negedge clk_sys);
      setpoint_write = 1'b0;
      setpoint_code = ~code;
   endtask
   // static level on the mode pin
   task automatic set_level(input logic lv);
      @(negedge clk_sys);
      mode_sync = lv;
   endtask
   // primary switching clock fed to a secondary
   task automatic sync_clock(input int edges);
      repeat (edges) begin
         repeat (4) @(negedge clk_sys);
         mode_sync = ~mode_sync;
      end
   endtask
endmodule

// >>> bench/test_vout_setpoint_dvs_mode_ctrl.sv
`timescale 1ns/1ns
`include "vout_setpoint_defs.svh"
module test_vout_setpoint_dvs_mode_ctrl;
   // ------------------------------
   // signals
   // ------------------------------
   logic clk_sys = 1'b0, rst, enable, single_strap_variant, strap_fine_offset, strap_coarse_offset;
   logic droop_enable, forced_pwm_bit, spread_enable, secondary_mode, mode_sync, setpoint_write;
   logic voltage_transition, softstart_active, forced_pwm, sync_locked, switch_clock_ext;
   logic spread_spectrum;
   logic [1:0] single_strap_select, strap_pin_a, strap_pin_b, range_select, softstart_time_sel;
   logic [1:0] slew_rate_sel, active_range, active_softstart_time;
   logic [7:0] setpoint_code, droop_offset, load_level, output_target_code, droop_target_code, maxc;
   logic [6:0] i2c_address;
   logic signed [7:0] spread_offset_pct, lo, hi;
   int mismatches = 0, checked = 0, k, t0, ex;
   int stepUv[3] = '{`STEP_UV_0, `STEP_UV_1, `STEP_UV_2};
   int slewUv[4] = '{`SLEW_UV_US_0, `SLEW_UV_US_1, `SLEW_UV_US_2, `SLEW_UV_US_3};
   int rngs[5] = '{2, 2, 2, 1, 0};
   int slews[5] = '{1, 2, 3, 3, 2};
   typedef struct packed {
      logic v; logic [1:0] s, a, b; logic f, c; logic [7:0] code; logic [6:0] addr;
   } row_s;
   row_s rows[8] = '{
      '{1, 0, 0, 0, 0, 0, `JE_CODE_LOW, `JE_ADDR_SHORT_GND}, '{1, 1, 0, 0, 0, 0, `JE_CODE_LOW, `JE_ADDR_RES_GND},
      '{1, 2, 0, 0, 0, 0, `JE_CODE_LOW, `JE_ADDR_RES_VIN}, '{1, 3, 0, 0, 0, 0, `JE_CODE_HIGH, `JE_ADDR_SHORT_VIN},
      '{0, 0, 0, 0, 0, 0, 8'h00, 7'h00}, '{0, 0, 0, 1, 1, 0, 8'h0F, 7'h00},
      '{0, 0, 2, 3, 0, 1, 8'hD2, 7'h00}, '{0, 0, 3, 3, 1, 1, 8'hFF, 7'h00}};
   // ------------------------------
   // design, host and clock
   // ------------------------------
   vout_setpoint_dvs_mode_ctrl #(.SOFTSTART_CYCLES(20), .SPREAD_STEPS(8))
   vout_setpoint_dvs_mode_ctrl_i (.clk_sys, .rst, .enable, .single_strap_variant,
      .single_strap_select, .strap_pin_a, .strap_pin_b, .strap_fine_offset, .strap_coarse_offset,
      .setpoint_code, .setpoint_write, .range_select, .softstart_time_sel, .slew_rate_sel,
      .droop_enable, .droop_offset, .load_level, .forced_pwm_bit, .spread_enable, .secondary_mode,
      .mode_sync, .output_target_code, .active_range, .active_softstart_time, .i2c_address,
      .voltage_transition, .softstart_active, .forced_pwm, .sync_locked, .switch_clock_ext,
      .spread_spectrum, .spread_offset_pct, .droop_target_code);
   host_model host_i (.clk_sys, .setpoint_code, .setpoint_write, .range_select,
      .softstart_time_sel, .mode_sync);
   always #20 clk_sys = ~clk_sys;
   // ------------------------------
   // helpers
   // ------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask
   task automatic wait_for(ref logic sig, input logic lvl, input int lim);
      int w;
      w = 0;
      while (sig !== lvl && w < lim) begin
         @(negedge clk_sys);
         w++;
      end
      check(sig, lvl, "wait for level");
   endtask
   task automatic wait_code(input logic [7:0] c);
      while (output_target_code !== c && k < 2000) begin
         @(negedge clk_sys);
         k++;
      end
   endtask
   task automatic restart();
      rst = 1'b1;
      enable = 1'b0;
      repeat (6) @(negedge clk_sys);
      rst = 1'b0;
      repeat (2) @(negedge clk_sys);
   endtask
   task automatic start();
      enable = 1'b1;
      wait_for(softstart_active, 1'b1, 10);
      wait_for(softstart_active, 1'b0, 8000);
   endtask
   task automatic stop_test();
      if (mismatches == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ------------------------------
   // watchdog and main sequence
   // ------------------------------
   initial begin
      repeat (80000) @(posedge clk_sys);
      mismatches++;
      stop_test();
   end
   initial begin
      {rst, enable, droop_enable, forced_pwm_bit, spread_enable, secondary_mode} = 6'h20;
      {single_strap_variant, strap_fine_offset, strap_coarse_offset} = 3'h4;
      {single_strap_select, strap_pin_a, strap_pin_b, slew_rate_sel} = 8'h00;
      {droop_offset, load_level} = 16'h0000;
      restart();
      check(output_target_code, 8'h00, "reset code");
      check(active_range, `RANGE_DEFAULT, "reset range");
      check({voltage_transition, softstart_active}, 2'b00, "reset flags");
      // strap decode rows
      for (int i = 0; i < 8; i++) begin
         {single_strap_variant, single_strap_select, strap_pin_a, strap_pin_b} = rows[i][23:17];
         {strap_fine_offset, strap_coarse_offset} = {rows[i].f, rows[i].c};
         restart();
         start();
         check(output_target_code, rows[i].code, "strap code");
         if (rows[i].v) check(i2c_address, rows[i].addr, "address");
      end
      // writes during soft-start and during a ramp are deferred
      {single_strap_variant, single_strap_select} = 3'h4;
      restart();
      enable = 1'b1;
      wait_for(softstart_active, 1'b1, 10);
      host_i.write_setpoint(8'h60, 2'h2, 1'b1);
      wait_for(softstart_active, 1'b0, 4000);
      check(output_target_code, `JE_CODE_LOW, "soft-start target");
      wait_for(voltage_transition, 1'b1, 10);
      host_i.write_setpoint(8'h58, 2'h0, 1'b1);
      wait_for(voltage_transition, 1'b0, 2000);
      check(output_target_code, 8'h60, "deferred code");
      check(active_softstart_time, 2'h2, "ss time deferred");
      check(active_range, 2'h2, "range during ramp");
      wait_for(voltage_transition, 1'b1, 10);
      wait_for(voltage_transition, 1'b0, 2000);
      check(output_target_code, 8'h58, "held code");
      check(active_range, 2'h0, "range applied");
      host_i.write_setpoint(8'h58, 2'h3, 1'b0);
      repeat (4) @(negedge clk_sys);
      check(active_range, 2'h0, "range without write");
      // settings written while disabled, step interval per rate and range
      single_strap_select = 2'h3;
      for (int j = 0; j < 5; j++) begin
         restart();
         slew_rate_sel = slews[j][1:0];
         host_i.write_setpoint(8'h10, rngs[j][1:0], 1'b1);
         enable = 1'b1;
         k = 0;
         wait_code(8'h01);
         t0 = k;
         wait_code(8'h02);
         ex = stepUv[rngs[j]] * (`CLK_KHZ / 1000) / slewUv[slews[j]];
         check(16'(k - t0), 16'(ex), "step interval");
         maxc = output_target_code;
         for (k = 0; k < 8000 && softstart_active !== 1'b0; k++) begin
            @(negedge clk_sys);
            if (output_target_code > maxc) maxc = output_target_code;
         end
         check(output_target_code, 8'h10, "programmed start");
         check(maxc, 8'h10, "direct start");
         check(active_range, rngs[j][1:0], "programmed range");
         check(active_softstart_time, 2'h1, "programmed ss time");
      end
      // droop around the nominal code
      enable = 1'b0;
      droop_offset = 8'h08;
      repeat (2) @(negedge clk_sys);
      droop_enable = 1'b1;
      start();
      repeat (3) @(negedge clk_sys);
      check(droop_target_code > output_target_code, 1'b1, "droop light load");
      load_level = 8'hFF;
      repeat (3) @(negedge clk_sys);
      check(droop_target_code < output_target_code, 1'b1, "droop full load");
      // mode pin and control bit
      for (int m = 0; m < 4; m++) begin
         host_i.set_level(m[0]);
         forced_pwm_bit = m[1];
         repeat (3) @(negedge clk_sys);
         check(forced_pwm, m != 0, "pwm select");
      end
      // spread spectrum sweep
      host_i.set_level(1'b0);
      spread_enable = 1'b1;
      repeat (100) @(negedge clk_sys);
      check(spread_spectrum, 1'b1, "spread on");
      {lo, hi} = 16'h0000;
      for (k = 0; k < 4000; k++) begin
         @(negedge clk_sys);
         if (spread_offset_pct < lo) lo = spread_offset_pct;
         if (spread_offset_pct > hi) hi = spread_offset_pct;
      end
      check({lo, hi}, {-8'sd10, 8'sd10}, "spread extremes");
      // external clock, then loss of it
      forced_pwm_bit = 1'b0;
      host_i.sync_clock(20);
      check({sync_locked, forced_pwm, switch_clock_ext}, 3'h7, "sync lock");
      check(spread_spectrum, 1'b0, "spread with sync");
      host_i.set_level(1'b0);
      repeat (200) @(negedge clk_sys);
      check(sync_locked, 1'b0, "sync lost");
      forced_pwm_bit = 1'b1;
      spread_enable = 1'b0;
      secondary_mode = 1'b1;
      repeat (3) @(negedge clk_sys);
      check(spread_spectrum, 1'b0, "spread off");
      check(switch_clock_ext, 1'b1, "secondary clock");
      stop_test();
   end
endmodule
